// >>> inc/ocd_pkg.sv
// Purpose: Shared constants for the option byte configuration decoder
// Assumes: APB with 32-bit data, one word per register
// Notes:   Field positions are bit indices within each option byte
package ocd_pkg;
    // APB register byte addresses
    localparam logic [7:0] STATUS_OFS  = 8'h00;
    localparam logic [7:0] WDG_CTL_OFS = 8'h04;
    localparam logic [7:0] ERASE_OFS   = 8'h08;

    // Option byte 0 field positions
    localparam int B0_STOP_WDG_RST = 7;
    localparam int B0_WATCHDOG_SOFTWARE_SELECT_SEL   = 6;
    localparam int B0_RSVD_HI      = 5;
    localparam int B0_RSVD_LO      = 1;
    localparam int B0_READOUT_N    = 0;

    // Option byte 1 field positions
    localparam int B1_PKG_SEL      = 7;
    localparam int B1_RST_DLY      = 6;
    localparam int B1_SRC_HI       = 5;
    localparam int B1_SRC_LO       = 4;
    localparam int B1_RANGE_HI     = 3;
    localparam int B1_RANGE_LO     = 1;
    localparam int B1_PLL_OFF      = 0;

    // Reserved bits of byte 0 as shipped from erase
    localparam logic [4:0] B0_RSVD_DEFAULT = 5'h13;

    // Clock source patterns
    localparam logic [1:0] SRC_RESONATOR = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL  = 2'h3;

    // Frequency range codes
    localparam logic [2:0] RANGE_1_TO_2MHZ  = 3'h0;
    localparam logic [2:0] RANGE_2_TO_4MHZ  = 3'h1;
    localparam logic [2:0] RANGE_4_TO_8MHZ  = 3'h2;
    localparam logic [2:0] RANGE_8_TO_16MHZ = 3'h3;

    // Reset phase lengths in CPU cycles
    localparam logic [12:0] RST_DLY_LONG  = 13'h1000;
    localparam logic [12:0] RST_DLY_SHORT = 13'h0100;

    // Reset value of the software watchdog enable
    localparam logic WATCHDOG_SOFTWARE_SELECT_EN_RESET = 1'b0;

    // Erase sequencer states
    typedef enum logic [1:0] {
        ERS_IDLE = 2'b00,
        ERS_USER = 2'b01,
        ERS_OPT  = 2'b10,
        ERS_DONE = 2'b11
    } ocd_ers_e;
endpackage : ocd_pkg

// >>> rtl/ocd_sync.sv
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs change slowly relative to sys_clk_i
// Notes:   No reset so pin levels flow through while reset is held
`timescale 1ns/100ps
`default_nettype none
module ocd_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) $error("ocd_sync: W must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        meta_reg <= async_i;
        sync_o   <= meta_reg;
    end
endmodule : ocd_sync
`default_nettype wire

// >>> rtl/ocd_decoder.sv
// Purpose: Decode the two option bytes into static hardware settings
// Assumes: Option bytes arrive as pin levels from the non-volatile array
// Notes:   Settings are captured while reset is held and frozen after
// Notes on behaviour
// - Option bit selects reset on stop entry
// - Option bit selects hardware or software watchdog
// - Protection active low blocks readout and writes
// - Protected erase wipes user memory first
// - Option bit selects 32 or 42/44 pins
// - Unbonded pads forced to pull-up input
// - Reset phase 4096 or 256 CPU cycles
// - Two bits select resonator or external clock
// - Three bits select frequency range
// - Option bit low enables clock doubler
// - Option bytes unmapped, reached in programming mode
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ocd_decoder #(
    parameter int          PAD_W         = 32,
    parameter logic [31:0] UNBONDED_MASK = 32'hFF00_0000
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    // APB slave
    input  wire logic [7:0]        paddr_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Non-volatile option bytes and programming pins
    input  wire logic [7:0]        opt_byte0_i,
    input  wire logic [7:0]        opt_byte1_i,
    input  wire logic              prog_mode_i,
    input  wire logic              prog_erase_req_i,
    input  wire logic              user_erase_done_i,
    input  wire logic              opt_erase_done_i,
    output logic                   user_erase_start_o,
    output logic                   opt_erase_start_o,
    output logic                   erase_busy_o,
    // Core side
    input  wire logic              stop_entry_i,
    output logic                   stop_reset_o,
    output logic                   watchdog_active_o,
    output logic                   readout_block_o,
    output logic                   flash_write_block_o,
    output logic                   package_select_o,
    output logic [PAD_W-1:0]       pad_pullup_force_o,
    output logic [12:0]            reset_delay_cycles_o,
    output logic                   clock_source_ext_o,
    output logic                   clock_source_bad_o,
    output logic [2:0]             oscillator_freq_range_o,
    output logic                   osc_drive_range_valid_o,
    output logic                   pll_enable_o,
    output logic                   pll_range_warn_o
);
    logic [7:0]           byte0_sync;
    logic [7:0]           byte1_sync;
    logic [2:0]           pin_sync;
    logic [7:0]           cfg0_reg;
    logic [7:0]           cfg1_reg;
    logic                 watchdog_software_select_en_reg;
    logic                 erase_req_d_reg;
    ocd_pkg::ocd_ers_e    ers_reg;
    ocd_pkg::ocd_ers_e    ers_next;
    logic                 erase_rise;
    logic                 readout_protect;
    logic                 wr_acc;
    logic                 rd_acc;
    logic                 addr_hit;
    logic [1:0]           clock_source_type;

    initial begin
        if (PAD_W < 1 || PAD_W > 32) $error("ocd_decoder: PAD_W must be 1..32");
    end

    // Address decode used only for the error response on unmapped addresses
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ocd_pkg::STATUS_OFS) || (a == ocd_pkg::WDG_CTL_OFS)
                 || (a == ocd_pkg::ERASE_OFS);
    endfunction : is_mapped

    // Pins from outside pass two flops before use, except opt_erase_done_i
    ocd_sync #(.W(8)) u_sync_b0 (
        .sys_clk_i (sys_clk_i),
        .async_i   (opt_byte0_i),
        .sync_o    (byte0_sync)
    );
    ocd_sync #(.W(8)) u_sync_b1 (
        .sys_clk_i (sys_clk_i),
        .async_i   (opt_byte1_i),
        .sync_o    (byte1_sync)
    );
    ocd_sync #(.W(3)) u_sync_pins (
        .sys_clk_i (sys_clk_i),
        .async_i   ({prog_mode_i, prog_erase_req_i, user_erase_done_i}),
        .sync_o    (pin_sync)
    );

    // Capture while reset is held; frozen afterwards so the core
    // never sees a setting change under it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg0_reg <= byte0_sync;
            cfg1_reg <= byte1_sync;
        end
    end

    // Stop entry reset only while the watchdog runs
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            stop_reset_o <= 1'b0;
        end else begin
            stop_reset_o <= stop_entry_i && watchdog_active_o
                         && cfg0_reg[ocd_pkg::B0_STOP_WDG_RST];
        end
    end

    // Software enable is set-only: a runaway program cannot stop it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            watchdog_software_select_en_reg <= ocd_pkg::WATCHDOG_SOFTWARE_SELECT_EN_RESET;
        end else if (wr_acc && paddr_i == ocd_pkg::WDG_CTL_OFS && pwdata_i[0]) begin
            watchdog_software_select_en_reg <= 1'b1;
        end
    end

    // Hardware type forces the watchdog on
    assign watchdog_active_o = !cfg0_reg[ocd_pkg::B0_WATCHDOG_SOFTWARE_SELECT_SEL] || watchdog_software_select_en_reg;

    // Protection bit is active low
    assign readout_protect     = !cfg0_reg[ocd_pkg::B0_READOUT_N];
    assign readout_block_o     = readout_protect;
    assign flash_write_block_o = readout_protect;

    // Package and unbonded pad handling
    assign package_select_o   = cfg1_reg[ocd_pkg::B1_PKG_SEL];
    assign pad_pullup_force_o = package_select_o ? '0
                              : UNBONDED_MASK[PAD_W-1:0];

    // Reset phase length, also used on stop exit
    assign reset_delay_cycles_o = cfg1_reg[ocd_pkg::B1_RST_DLY]
                                ? ocd_pkg::RST_DLY_SHORT
                                : ocd_pkg::RST_DLY_LONG;

    // Clock source; reserved patterns are flagged, not decoded
    assign clock_source_type  = cfg1_reg[ocd_pkg::B1_SRC_HI:ocd_pkg::B1_SRC_LO];
    assign clock_source_ext_o = clock_source_type == ocd_pkg::SRC_EXTERNAL;
    assign clock_source_bad_o = clock_source_type != ocd_pkg::SRC_EXTERNAL
                             && clock_source_type != ocd_pkg::SRC_RESONATOR;

    // Range field: drive current with a resonator, else operating range
    assign oscillator_freq_range_o =
        cfg1_reg[ocd_pkg::B1_RANGE_HI:ocd_pkg::B1_RANGE_LO];
    assign osc_drive_range_valid_o =
        clock_source_type == ocd_pkg::SRC_RESONATOR;

    // Doubler enable is active low; misuse only flagged
    assign pll_enable_o     = !cfg1_reg[ocd_pkg::B1_PLL_OFF];
    assign pll_range_warn_o = pll_enable_o
                           && oscillator_freq_range_o != ocd_pkg::RANGE_2_TO_4MHZ;

    // Erase request edge, honoured only in programming mode
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            erase_req_d_reg <= 1'b0;
        end else begin
            erase_req_d_reg <= pin_sync[1];
        end
    end
    assign erase_rise = pin_sync[1] && !erase_req_d_reg && pin_sync[2];

    // Erase sequencer: a protected part wipes user memory before
    // the option bytes, so no secret survives the unlock
    always_comb begin
        ers_next = ers_reg;
        case (ers_reg)
            ocd_pkg::ERS_IDLE: begin
                if (erase_rise) begin
                    ers_next = readout_protect ? ocd_pkg::ERS_USER
                                               : ocd_pkg::ERS_OPT;
                end
            end
            ocd_pkg::ERS_USER: begin
                if (pin_sync[0]) ers_next = ocd_pkg::ERS_OPT;
            end
            ocd_pkg::ERS_OPT: begin
                if (opt_erase_done_i) ers_next = ocd_pkg::ERS_DONE;
            end
            ocd_pkg::ERS_DONE: begin
                ers_next = ocd_pkg::ERS_IDLE;
            end
            default: ers_next = ocd_pkg::ERS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ers_reg <= ocd_pkg::ERS_IDLE;
        end else begin
            ers_reg <= ers_next;
        end
    end

    // Start pulses on state entry
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            user_erase_start_o <= 1'b0;
            opt_erase_start_o  <= 1'b0;
        end else begin
            user_erase_start_o <= ers_reg != ocd_pkg::ERS_USER
                               && ers_next == ocd_pkg::ERS_USER;
            opt_erase_start_o  <= ers_reg != ocd_pkg::ERS_OPT
                               && ers_next == ocd_pkg::ERS_OPT;
        end
    end
    assign erase_busy_o = ers_reg != ocd_pkg::ERS_IDLE;

    // APB: zero wait states, unmapped addresses answer with an error;
    // the option bytes themselves have no address here
    assign wr_acc    = psel_i && penable_i && pwrite_i;
    assign rd_acc    = psel_i && !penable_i && !pwrite_i;
    assign addr_hit  = is_mapped(paddr_i);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

    // Read data registered in the setup cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (paddr_i)
                ocd_pkg::STATUS_OFS: prdata_o <= {16'h0000, pll_range_warn_o,
                    clock_source_bad_o, watchdog_active_o, readout_protect,
                    package_select_o, cfg1_reg[ocd_pkg::B1_RST_DLY],
                    clock_source_type, oscillator_freq_range_o,
                    pll_enable_o, cfg0_reg[ocd_pkg::B0_STOP_WDG_RST],
                    cfg0_reg[ocd_pkg::B0_WATCHDOG_SOFTWARE_SELECT_SEL], stop_reset_o, 1'b0};
                ocd_pkg::WDG_CTL_OFS: prdata_o <= {31'h0000_0000, watchdog_software_select_en_reg};
                ocd_pkg::ERASE_OFS: prdata_o <= {29'h0000_0000, pin_sync[2],
                    ers_reg};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_prot_erase_go;
        erase_rise && ers_reg == ocd_pkg::ERS_IDLE && readout_protect;
    endsequence
    // Start pulse is registered from the next state, so it lands with USER
    sequence s_user_first;
        ##1 (ers_reg == ocd_pkg::ERS_USER && user_erase_start_o)
        ##1 (ers_reg == ocd_pkg::ERS_USER && !user_erase_start_o);
    endsequence

    a_cfg_held_stable: assert property ($stable(cfg0_reg) && $stable(cfg1_reg))
        else $error("option settings changed outside reset");
    a_stop_reset_set: assert property (stop_entry_i && watchdog_active_o
        && cfg0_reg[ocd_pkg::B0_STOP_WDG_RST] |=> stop_reset_o)
        else $error("stop entry did not raise reset");
    a_stop_reset_off: assert property (!cfg0_reg[ocd_pkg::B0_STOP_WDG_RST]
        |=> !stop_reset_o)
        else $error("stop reset raised while disabled");
    a_wdg_hw_on: assert property (!cfg0_reg[ocd_pkg::B0_WATCHDOG_SOFTWARE_SELECT_SEL]
        |-> watchdog_active_o)
        else $error("hardware watchdog not active");
    a_watchdog_software_select_idle: assert property (cfg0_reg[ocd_pkg::B0_WATCHDOG_SOFTWARE_SELECT_SEL]
        && !watchdog_software_select_en_reg |-> !watchdog_active_o)
        else $error("software watchdog active before enable");
    a_protect_level: assert property (readout_block_o == !cfg0_reg[0]
        && flash_write_block_o == !cfg0_reg[0])
        else $error("protection outputs wrong polarity");
    a_erase_user_first: assert property (s_prot_erase_go |-> s_user_first)
        else $error("protected erase skipped user memory");
    a_opt_after_user: assert property ($rose(opt_erase_start_o) && readout_protect
        |-> $past(ers_reg, 2) == ocd_pkg::ERS_USER)
        else $error("option erase before user erase");
    a_pad_pullup: assert property (!package_select_o
        |-> pad_pullup_force_o == UNBONDED_MASK[PAD_W-1:0])
        else $error("unbonded pads not forced");
    a_rst_delay_len: assert property (reset_delay_cycles_o ==
        (cfg1_reg[6] ? 13'h0100 : 13'h1000))
        else $error("reset delay length wrong");
    a_clk_src_ext: assert property (clock_source_ext_o == (cfg1_reg[5:4] == 2'h3))
        else $error("clock source decode wrong");
    a_pll_polarity: assert property (pll_enable_o != cfg1_reg[0])
        else $error("doubler enable wrong polarity");
    a_range_pass: assert property (oscillator_freq_range_o == cfg1_reg[3:1])
        else $error("range field misrouted");
    a_unmapped_err: assert property (psel_i && penable_i && !is_mapped(paddr_i)
        |-> pslverr_o)
        else $error("unmapped access without error");
endmodule : ocd_decoder
`default_nettype wire

// >>> test/ocd_tool_model.sv
// Purpose: Programming tool and option array stand-in
// Assumes: Bench commands arrive on plain inputs
// Notes:   Done lines are driven low when idle, no pulls on them
`timescale 1ns/100ps
`default_nettype none
module ocd_tool_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] b0_i,
    input  wire logic [7:0] b1_i,
    input  wire logic       prog_i,
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic       user_start_i,
    input  wire logic       opt_start_i,
    output logic      [7:0] byte0_o,
    output logic      [7:0] byte1_o,
    output logic            prog_mode_o,
    output logic            erase_req_o,
    output logic            user_done_o,
    output logic            opt_done_o
);
    logic [5:0] req_cnt;
    logic [5:0] u_cnt;
    logic [5:0] o_cnt;

    // Erased array content until the tool writes it
    initial begin
        byte0_o     = 8'hFF;
        byte1_o     = 8'hFF;
        req_cnt     = 6'h00;
        u_cnt       = 6'h00;
        o_cnt       = 6'h00;
        user_done_o = 1'b0;
        opt_done_o  = 1'b0;
    end

    assign prog_mode_o = prog_i;
    assign erase_req_o = (req_cnt != 6'h00);

    // Bytes are only writable in programming mode
    always @(posedge sys_clk_i) begin
        if (prog_i) begin
            byte0_o <= b0_i;
            byte1_o <= b1_i;
        end
    end

    // Request held long enough for the synchroniser; memory answers late or soon
    always @(posedge sys_clk_i) begin
        req_cnt <= go_i ? 6'h04 : ((req_cnt != 6'h00) ? req_cnt - 6'h01 : req_cnt);
        if (user_start_i)
            u_cnt <= slow_i ? 6'h20 : 6'h02;
        else if (u_cnt != 6'h00)
            u_cnt <= u_cnt - 6'h01;
        if (u_cnt == 6'h01)
            user_done_o <= 1'b1;
        if (opt_start_i)
            user_done_o <= 1'b0;
        if (opt_start_i)
            o_cnt <= slow_i ? 6'h18 : 6'h03;
        else if (o_cnt != 6'h00)
            o_cnt <= o_cnt - 6'h01;
        opt_done_o <= (o_cnt == 6'h01);
    end
endmodule : ocd_tool_model
`default_nettype wire

// >>> test/option_byte_config_decoder_test.sv
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Zero-wait APB slave, bytes captured while reset is held
// Notes:   Drivers note expectations, a watcher compares on results
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module option_byte_config_decoder_test;
    localparam logic [31:0] MASK = 32'hFF00_0000;
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, stop_entry_i = 1'b0, prog = 1'b0, go = 1'b0, slow = 1'b0;
    logic [7:0]  paddr_i = 8'h00, b0 = 8'hFF, b1 = 8'hFF, a, c;
    logic [31:0] pwdata_i = 32'h0000_0000, seed, prdata_o, pad_pullup_force_o;
    logic [1:0]  chk = 2'b00, ex;
    logic        pready_o, pslverr_o, user_erase_start_o, opt_erase_start_o, erase_busy_o;
    logic        stop_reset_o, watchdog_active_o, readout_block_o, flash_write_block_o;
    logic        package_select_o, clock_source_ext_o, clock_source_bad_o, es;
    logic        osc_drive_range_valid_o, pll_enable_o, pll_range_warn_o;
    logic        prog_mode_i, prog_erase_req_i, user_erase_done_i, opt_erase_done_i;
    logic [7:0]  opt_byte0_i, opt_byte1_i;
    logic [12:0] reset_delay_cycles_o;
    logic [2:0]  oscillator_freq_range_o;
    logic [56:0] obs, ec;
    logic [33:0] na;
    logic [56:0] q_cfg[$];
    logic [33:0] q_apb[$];
    logic [1:0]  q_ers[$];
    logic        q_stop[$];
    int          num_errors = 0;
    int          samples_checked = 0;

    ocd_decoder #(.PAD_W(32), .UNBONDED_MASK(MASK)) DUT (.sys_clk_i, .rst_n_i, .paddr_i,
        .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .opt_byte0_i, .opt_byte1_i, .prog_mode_i, .prog_erase_req_i, .user_erase_done_i,
        .opt_erase_done_i, .user_erase_start_o, .opt_erase_start_o, .erase_busy_o,
        .stop_entry_i, .stop_reset_o, .watchdog_active_o, .readout_block_o,
        .flash_write_block_o, .package_select_o, .pad_pullup_force_o, .reset_delay_cycles_o,
        .clock_source_ext_o, .clock_source_bad_o, .oscillator_freq_range_o,
        .osc_drive_range_valid_o, .pll_enable_o, .pll_range_warn_o);
    ocd_tool_model u_tool (.sys_clk_i, .b0_i(b0), .b1_i(b1), .prog_i(prog), .go_i(go),
        .slow_i(slow), .user_start_i(user_erase_start_o), .opt_start_i(opt_erase_start_o),
        .byte0_o(opt_byte0_i), .byte1_o(opt_byte1_i), .prog_mode_o(prog_mode_i),
        .erase_req_o(prog_erase_req_i), .user_done_o(user_erase_done_i),
        .opt_done_o(opt_erase_done_i));

    // All decoded settings in one vector
    assign obs = {watchdog_active_o, readout_block_o, flash_write_block_o, package_select_o,
        pad_pullup_force_o, reset_delay_cycles_o, clock_source_ext_o, clock_source_bad_o,
        oscillator_freq_range_o, osc_drive_range_valid_o, pll_enable_o, pll_range_warn_o};

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    endfunction : xs

    function automatic logic [56:0] exp_cfg(input logic [7:0] p, input logic [7:0] q);
        exp_cfg = {!p[6], !p[0], !p[0], q[7], q[7] ? 32'h0000_0000 : MASK,
            q[6] ? ocd_pkg::RST_DLY_SHORT : ocd_pkg::RST_DLY_LONG, q[5:4] == 2'h3,
            q[5] ^ q[4], q[3:1], q[5:4] == 2'h0, !q[0],
            (!q[0] && (q[3:1] != ocd_pkg::RANGE_2_TO_4MHZ))};
    endfunction : exp_cfg

    function automatic logic [31:0] stat(input logic [7:0] p, input logic [7:0] q, input logic sw);
        stat = {16'h0000, (!q[0] && (q[3:1] != ocd_pkg::RANGE_2_TO_4MHZ)), q[5] ^ q[4],
            (!p[6] | sw), !p[0], q[7:1], !q[0], p[7:6], 2'b00};
    endfunction : stat

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    task automatic test_done();
        num_errors += q_cfg.size() + q_apb.size() + q_ers.size() + q_stop.size();
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic [7:0] ad, input logic wr, input logic [31:0] wd,
                       input logic err, input logic [31:0] rd);
        int k;
        q_apb.push_back({!wr, err, rd});
        paddr_i <= ad;
        pwrite_i <= wr;
        pwdata_i <= wd;
        psel_i <= 1'b1;
        tick(1);
        penable_i <= 1'b1;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (pready_o !== 1'b1) begin
            num_errors++;
            test_done();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Idle edge so the next setup never reassigns psel in this step
        tick(1);
    endtask : apb

    task automatic note(input logic [1:0] kind);
        chk <= kind;
        tick(1);
        chk <= 2'b00;
    endtask : note

    task automatic stop_chk(input logic e);
        q_stop.push_back(e);
        stop_entry_i <= 1'b1;
        tick(1);
        stop_entry_i <= 1'b0;
        note(2'b10);
    endtask : stop_chk

    task automatic load(input logic [7:0] p, input logic [7:0] q, input logic rs);
        b0 <= p;
        b1 <= q;
        prog <= 1'b1;
        tick(1);
        prog <= 1'b0;
        rst_n_i <= !rs;
        tick(5);
        rst_n_i <= 1'b1;
        tick(1);
    endtask : load

    task automatic erase(input logic unprot);
        int k;
        if (!unprot)
            q_ers.push_back(2'b10);
        q_ers.push_back(2'b01);
        prog <= 1'b1;
        tick(4);
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        k = 0;
        while (erase_busy_o !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        while (erase_busy_o !== 1'b0 && k < 300) begin
            tick(1);
            k++;
        end
        if (erase_busy_o !== 1'b0) begin
            num_errors++;
            test_done();
        end
        prog <= 1'b0;
        tick(2);
    endtask : erase

    // Watcher takes the oldest note whenever a result shows
    always @(posedge sys_clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            na = q_apb.pop_front();
            `CHK({pslverr_o, na[33] ? prdata_o : 32'h0}, na[32:0])
        end
        if (chk == 2'b01) begin
            ec = q_cfg.pop_front();
            `CHK(obs[56:21], ec[56:21])
            `CHK(obs[20:0], ec[20:0])
        end
        if (chk == 2'b10) begin
            es = q_stop.pop_front();
            `CHK(stop_reset_o, es)
        end
        if (user_erase_start_o || opt_erase_start_o) begin
            ex = (q_ers.size() > 0) ? q_ers.pop_front() : 2'b00;
            `CHK({user_erase_start_o, opt_erase_start_o}, ex)
        end
    end

    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        tick(100000);
        num_errors++;
        test_done();
    end

    // Every source and range code, both protection states, random rest
    initial begin
        seed = 32'h0000_387F;
        tick(5);
        rst_n_i <= 1'b1;
        tick(1);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            a = {seed[7:6], ocd_pkg::B0_RSVD_DEFAULT, i[0]};
            c = {seed[15], seed[14] & (i[1:0] != 2'b00), i[1:0], 1'b0, i[2:1],
                seed[20] | (i[2:1] != 2'b01)};
            load(a, c, 1'b1);
            q_cfg.push_back(exp_cfg(a, c));
            note(2'b01);
            apb(ocd_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0, stat(a, c, 1'b0));
            apb(ocd_pkg::ERASE_OFS, 1'b0, 32'h0, 1'b0, 32'h0);
            apb(8'h0C, 1'b1, seed, 1'b1, 32'h0);
            apb(8'h0C, 1'b0, 32'h0, 1'b1, 32'h0);
            apb(ocd_pkg::WDG_CTL_OFS, 1'b1, 32'h0, 1'b0, 32'h0);
            stop_chk(a[7] & !a[6]);
            load(a ^ 8'hC1, c ^ 8'h80, 1'b0);
            tick(4);
            q_cfg.push_back(exp_cfg(a, c));
            note(2'b01);
            apb(ocd_pkg::WDG_CTL_OFS, 1'b1, {seed[31:1], 1'b1}, 1'b0, 32'h0);
            apb(ocd_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0, stat(a, c, 1'b1));
            stop_chk(a[7]);
            slow <= i[2];
            erase(a[0]);
        end
        tick(4);
        test_done();
    end
endmodule : option_byte_config_decoder_test
`default_nettype wire
